// ---- rtl/dtr_regs.sv ----
// Functional notes
// - Right layout: ch0 low byte is bits 7:0
// - Left layout: ch0 low upper nibble, low zero
// - Right layout: ch1 high nibble bits 11:8
// - Left layout: ch1 high byte bits 11:4
// - Right layout: ch1 low byte bits 7:0
// - Left layout: ch1 low bits 3:0 in 7:4, rest zero
// - Channel 0 gain trim, 8 bits, reset zero
// - Channel 0 offset trim, 8 bits, reset zero
// - Channel 1 gain trim, 8 bits, reset zero
// - Channel 1 offset trim, 8 bits, reset zero
// - Right layout default, left when select set
// - Left layout high-only write gives 8-bit
// - Empty flag per channel, drives DMA request
`timescale 1ns/1ns
`default_nettype none
module dtr_regs
  import dtr_pkg::*;
(
  input wire logic clk,                 // Peripheral clock
  input wire logic resetn,              // Async reset, active low
  input wire logic ce,                  // Clock enable, freezes all state
  input wire logic [4:0] addr,          // Register offset
  input wire logic [7:0] wdata,         // Write data
  input wire logic wr,                  // Write strobe
  input wire logic rd,                  // Read strobe
  input wire logic [1:0] consume,       // Core took channel value
  output logic [7:0] rdata,             // Read data, cycle after rd
  output logic [11:0] ch0_value,        // Channel 0 conversion value
  output logic [11:0] ch1_value,        // Channel 1 conversion value
  output logic [7:0] ch0_gain_trim,     // Channel 0 gain trim
  output logic [7:0] ch0_offset_trim,   // Channel 0 offset trim
  output logic [7:0] ch1_gain_trim,     // Channel 1 gain trim
  output logic [7:0] ch1_offset_trim,   // Channel 1 offset trim
  output logic [7:0] control_a,         // Control A to core
  output logic [7:0] control_b,         // Control B to core
  output logic [7:0] control_c,         // Control C to core
  output logic [7:0] trigger_select,    // Trigger select to core
  output logic [1:0] dma_req,           // Empty flags as DMA requests
  output logic irq                      // Level interrupt
);
  // ==========================================================================
  // Control and trim registers
  // ==========================================================================
  logic [7:0] ctrl_a_reg, ctrl_b_reg, ctrl_c_reg, trig_reg;
  logic [7:0] g0_reg, o0_reg, g1_reg, o1_reg;
  logic [1:0] mask_reg;
  logic [1:0] status_reg;
  logic [7:0] rdata_reg;
  logic [11:0] v0_reg, v1_reg;
  logic [1:0] dma_reg;
  logic irq_reg;
  logic wr_en;
  logic left;

  assign wr_en = ce && wr;
  assign left = ctrl_c_reg[LEFT_ALIGN_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_reg <= RESET_BYTE;
      ctrl_b_reg <= RESET_BYTE;
      ctrl_c_reg <= RESET_BYTE;
      trig_reg <= RESET_BYTE;
      mask_reg <= RESET_FLAGS;
    end else if (wr_en) begin
      case (addr)
        OFS_CTRL_A: ctrl_a_reg <= wdata & CTRL_A_MASK;
        OFS_CTRL_B: ctrl_b_reg <= wdata & CTRL_B_MASK;
        OFS_CTRL_C: ctrl_c_reg <= wdata & CTRL_C_MASK;
        OFS_TRIG_SEL: trig_reg <= wdata & TRIG_SEL_MASK;
        OFS_IRQ_MASK: mask_reg <= wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      g0_reg <= RESET_BYTE;
      o0_reg <= RESET_BYTE;
      g1_reg <= RESET_BYTE;
      o1_reg <= RESET_BYTE;
    end else if (wr_en) begin
      case (addr)
        OFS_CH0_GAIN: g0_reg <= wdata;
        OFS_CH0_OFFSET: o0_reg <= wdata;
        OFS_CH1_GAIN: g1_reg <= wdata;
        OFS_CH1_OFFSET: o1_reg <= wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Channel data holders
  // ==========================================================================
  dtr_chan_if cif [NUM_CH] ();
  logic [11:0] val [NUM_CH];
  logic [NUM_CH-1:0] empty;
  logic [NUM_CH-1:0] commit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [4:0] LOW_OFS = (gi == 0) ? OFS_CH0_LOW : OFS_CH1_LOW;
      localparam logic [4:0] HIGH_OFS = (gi == 0) ? OFS_CH0_HIGH : OFS_CH1_HIGH;
      // Software keeps reserved positions zero; the layout drops them anyway
      assign cif[gi].low_wr = wr && (addr == LOW_OFS);
      assign cif[gi].high_wr = wr && (addr == HIGH_OFS);
      assign cif[gi].left_align = left;
      assign cif[gi].wdata = wdata;
      assign val[gi] = cif[gi].value;
      assign empty[gi] = cif[gi].empty;
      assign commit[gi] = cif[gi].committed;
      dtr_chan u_chan (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .consume(consume[gi]),
        .bus(cif[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Interrupt status: set on the empty flag rising, write one to clear
  // ==========================================================================
  logic [1:0] empty_d_reg;
  logic [1:0] rise;
  logic [1:0] clr;

  assign rise = empty & ~empty_d_reg;
  assign clr = (wr && addr == OFS_EMPTY_FLAGS) ? (wdata[1:0] & ~commit) : 2'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      empty_d_reg <= RESET_FLAGS;
    end else if (ce) begin
      empty_d_reg <= empty;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= RESET_FLAGS;
    end else if (ce) begin
      status_reg <= (status_reg & ~clr) | rise;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      v0_reg <= RESET_VALUE;
      v1_reg <= RESET_VALUE;
      dma_reg <= RESET_FLAGS;
      irq_reg <= RESET_BIT;
    end else if (ce) begin
      v0_reg <= val[0];
      v1_reg <= val[1];
      dma_reg <= empty;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================================
  // Read path; unmapped offsets read zero
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= RESET_BYTE;
    end else if (ce) begin
      rdata_reg <= RESET_BYTE;
      if (rd) begin
        case (addr)
          OFS_CTRL_A: rdata_reg <= ctrl_a_reg;
          OFS_CTRL_B: rdata_reg <= ctrl_b_reg;
          OFS_CTRL_C: rdata_reg <= ctrl_c_reg;
          OFS_TRIG_SEL: rdata_reg <= trig_reg;
          OFS_EMPTY_FLAGS: rdata_reg <= {6'h00, empty};
          OFS_IRQ_MASK: rdata_reg <= {4'h0, status_reg, mask_reg};
          OFS_CH0_GAIN: rdata_reg <= g0_reg;
          OFS_CH0_OFFSET: rdata_reg <= o0_reg;
          OFS_CH1_GAIN: rdata_reg <= g1_reg;
          OFS_CH1_OFFSET: rdata_reg <= o1_reg;
          OFS_CH0_LOW: rdata_reg <= left ? {val[0][3:0], 4'h0} : val[0][7:0];
          OFS_CH0_HIGH: rdata_reg <= left ? val[0][11:4] : {4'h0, val[0][11:8]};
          OFS_CH1_LOW: rdata_reg <= left ? {val[1][3:0], 4'h0} : val[1][7:0];
          OFS_CH1_HIGH: rdata_reg <= left ? val[1][11:4] : {4'h0, val[1][11:8]};
          default: rdata_reg <= RESET_BYTE;
        endcase
      end
    end
  end

  assign rdata = rdata_reg;
  assign ch0_value = v0_reg;
  assign ch1_value = v1_reg;
  assign ch0_gain_trim = g0_reg;
  assign ch0_offset_trim = o0_reg;
  assign ch1_gain_trim = g1_reg;
  assign ch1_offset_trim = o1_reg;
  assign control_a = ctrl_a_reg;
  assign control_b = ctrl_b_reg;
  assign control_c = ctrl_c_reg;
  assign trigger_select = trig_reg;
  assign dma_req = dma_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// ---- shared/dtr_pkg.sv ----
package dtr_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h01;
  localparam logic [4:0] OFS_CTRL_C = 5'h02;
  localparam logic [4:0] OFS_TRIG_SEL = 5'h03;
  localparam logic [4:0] OFS_EMPTY_FLAGS = 5'h05;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h06;
  localparam logic [4:0] OFS_CH0_GAIN = 5'h08;
  localparam logic [4:0] OFS_CH0_OFFSET = 5'h09;
  localparam logic [4:0] OFS_CH1_GAIN = 5'h0A;
  localparam logic [4:0] OFS_CH1_OFFSET = 5'h0B;
  localparam logic [4:0] OFS_CH0_LOW = 5'h18;
  localparam logic [4:0] OFS_CH0_HIGH = 5'h19;
  localparam logic [4:0] OFS_CH1_LOW = 5'h1A;
  localparam logic [4:0] OFS_CH1_HIGH = 5'h1B;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int LEFT_ALIGN_BIT = 0;
  localparam logic [7:0] CTRL_A_MASK = 8'h1F;
  localparam logic [7:0] CTRL_B_MASK = 8'h63;
  localparam logic [7:0] CTRL_C_MASK = 8'h19;
  localparam logic [7:0] TRIG_SEL_MASK = 8'h0F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_VALUE = 12'h000;
  localparam logic [1:0] RESET_FLAGS = 2'h0;
  localparam logic RESET_BIT = 1'b0;
  localparam int NUM_CH = 2;

endpackage

// ---- shared/dtr_chan_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Write events from the register decoder to one channel's data holder
interface dtr_chan_if;
  logic low_wr;
  logic high_wr;
  logic left_align;
  logic [7:0] wdata;
  logic [11:0] value;
  logic empty;
  logic committed;
  modport dec (output low_wr, high_wr, left_align, wdata, input value, empty, committed);
  modport chan (input low_wr, high_wr, left_align, wdata, output value, empty, committed);
endinterface
`default_nettype wire

// ---- rtl/dtr_chan.sv ----
`timescale 1ns/1ns
`default_nettype none
module dtr_chan
  import dtr_pkg::*;
(
  input wire logic clk,          // Peripheral clock
  input wire logic resetn,       // Async reset, active low
  input wire logic ce,           // Clock enable
  input wire logic consume,      // Core took the value
  dtr_chan_if.chan bus           // Decoder side
);
  // ==========================================================================
  // Staging and commit
  // ==========================================================================
  logic [7:0] stage_reg;
  logic [11:0] value_reg;
  logic empty_reg;
  logic [11:0] value_next;

  always_comb begin
    if (bus.left_align) begin
      value_next = {bus.wdata, stage_reg[7:4]};
    end else begin
      value_next = {bus.wdata[3:0], stage_reg};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_reg <= RESET_BYTE;
    end else if (ce && bus.low_wr) begin
      stage_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value_reg <= RESET_VALUE;
    end else if (ce && bus.high_wr) begin
      value_reg <= value_next;
    end
  end

  // Commit wins over the core's consume in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      empty_reg <= RESET_BIT;
    end else if (ce) begin
      if (bus.high_wr) begin
        empty_reg <= 1'b0;
      end else if (consume) begin
        empty_reg <= 1'b1;
      end
    end
  end

  assign bus.value = value_reg;
  assign bus.empty = empty_reg;
  assign bus.committed = bus.high_wr;
endmodule
`default_nettype wire

// ---- verif/dtr_regs_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module dtr_regs_assertions
  import dtr_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic ce, // Enable
  input wire logic [4:0] addr, // Offset
  input wire logic [7:0] wdata, // Data in
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [1:0] consume, // Taken
  input wire logic [7:0] rdata, // Data out
  input wire logic [11:0] ch1_value, // Value
  input wire logic [7:0] ch0_gain_trim, // Trim
  input wire logic [7:0] ch0_offset_trim, // Trim
  input wire logic [7:0] ch1_gain_trim, // Trim
  input wire logic [7:0] ch1_offset_trim, // Trim
  input wire logic [7:0] control_c, // Layout
  input wire logic [1:0] dma_req, // Requests
  input wire logic irq // Interrupt
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire we = wr && ce;
  wire re = rd && ce;
  a_rdata_idle_zero:
    assert property ($past(ce) && !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_gain0_write:
    assert property (we && addr == OFS_CH0_GAIN |=> ch0_gain_trim == $past(wdata))
    else $error("ch0 gain trim");
  a_offset0_write:
    assert property (we && addr == OFS_CH0_OFFSET |=> ch0_offset_trim == $past(wdata))
    else $error("ch0 offset trim");
  a_gain1_write:
    assert property (we && addr == OFS_CH1_GAIN |=> ch1_gain_trim == $past(wdata))
    else $error("ch1 gain trim");
  a_offset1_write:
    assert property (we && addr == OFS_CH1_OFFSET |=> ch1_offset_trim == $past(wdata))
    else $error("ch1 offset trim");
  a_right_high_commit:
    assert property (we && addr == OFS_CH1_HIGH && !control_c[0]
      |-> ##2 ch1_value[11:8] == $past(wdata[3:0], 2)) else $error("right high commit");
  a_left_high_commit:
    assert property (we && addr == OFS_CH1_HIGH && control_c[0]
      |-> ##2 ch1_value[11:4] == $past(wdata, 2)) else $error("left high commit");
  a_empty_cleared:
    assert property (we && addr == OFS_CH1_HIGH && !consume[1] ##1 !consume[1]
      |=> !dma_req[1]) else $error("empty flag not cleared");
  a_left_low_read:
    assert property (re && control_c[0] && (addr == OFS_CH0_LOW || addr == OFS_CH1_LOW)
      |=> rdata[3:0] == 4'h0) else $error("reserved nibble not zero");
  c_left_commit: cover property (we && addr == OFS_CH1_HIGH && control_c[0]);
  c_irq_rise: cover property ($rose(irq));
  c_dma_rise: cover property ($rose(dma_req[1]));
endmodule
bind dtr_regs dtr_regs_assertions chk_u (.clk, .resetn, .ce, .addr, .wdata, .wr, .rd,
  .consume, .rdata, .ch1_value, .ch0_gain_trim, .ch0_offset_trim, .ch1_gain_trim,
  .ch1_offset_trim, .control_c, .dma_req, .irq);
`default_nettype wire

// ---- verif/dtr_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module dtr_regs_tb
  import dtr_pkg::*;
;
  logic clk = 0, resetn = 0, ce = 1, wr = 0, rd = 0, irq;
  logic [4:0] addr = 0, lo;
  logic [7:0] wdata = 0, rdata, ch0_gain_trim, ch0_offset_trim, ch1_gain_trim;
  logic [7:0] ch1_offset_trim, control_a, control_b, control_c, trigger_select, b;
  logic [1:0] consume = 0, dma_req;
  logic [11:0] ch0_value, ch1_value, v;
  logic [7:0] trim [4];
  int n_mismatch = 0, num_checks = 0;
  always #2 clk = ~clk;
  dtr_regs dut_u (.clk, .resetn, .ce, .addr, .wdata, .wr, .rd, .consume, .rdata,
    .ch0_value, .ch1_value, .ch0_gain_trim, .ch0_offset_trim, .ch1_gain_trim,
    .ch1_offset_trim, .control_a, .control_b, .control_c, .trigger_select, .dma_req, .irq);
  // ==========================================================
  // Bus tasks
  task automatic step(input logic w, r, input logic [1:0] c, input logic [4:0] a,
                      input logic [7:0] d);
    wr <= w;
    rd <= r;
    consume <= c;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    step(1, 0, 2'b00, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) step(0, 0, 2'b00, 5'h00, 8'h00);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    step(0, 1, 2'b00, a, 8'h00);
    rd <= 0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask
  task automatic wait_irq(input logic e);
    @(negedge clk);
    for (int k = 0; k < 8 && irq !== e; k++) @(negedge clk);
    `CHK(irq, e)
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'hB04C));
    repeat (20) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    `CHK({ch0_value, ch1_value, dma_req, irq}, 27'h0)
    for (int a = 0; a < 28; a++) rd_chk(5'(a), 8'h00);
    // Reserved control bits must stay zero whatever software writes
    for (int i = 0; i < 4; i++) begin
      trim[i] = 8'($urandom);
      wr_reg(5'(i), trim[i]);
    end
    idle(1);
    `CHK({control_a, control_b}, {trim[0] & CTRL_A_MASK, trim[1] & CTRL_B_MASK})
    `CHK({control_c, trigger_select}, {trim[2] & CTRL_C_MASK, trim[3] & TRIG_SEL_MASK})
    rd_chk(OFS_CTRL_B, trim[1] & CTRL_B_MASK);
    for (int i = 0; i < 4; i++) begin
      trim[i] = 8'($urandom);
      wr_reg(5'(8 + i), trim[i]);
    end
    // Unmapped write and a write while frozen must both be lost
    wr_reg(5'h04, 8'hFF);
    ce <= 0;
    wr_reg(OFS_CH0_GAIN, ~trim[0]);
    ce <= 1;
    `CHK({ch0_gain_trim, ch0_offset_trim, ch1_gain_trim, ch1_offset_trim}, {trim[0], trim[1], trim[2], trim[3]})
    for (int i = 0; i < 4; i++) rd_chk(5'(8 + i), trim[i]);
    rd_chk(5'h04, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr_reg(OFS_CTRL_C, 8'(m));
      for (int c = 0; c < 2; c++) begin
        v = 12'($urandom);
        lo = c ? OFS_CH1_LOW : OFS_CH0_LOW;
        wr_reg(lo, m ? {v[3:0], 4'h0} : v[7:0]);
        wr_reg(lo + 5'h01, m ? v[11:4] : {4'h0, v[11:8]});
        idle(2);
        `CHK(c ? ch1_value : ch0_value, v)
        rd_chk(lo, m ? {v[3:0], 4'h0} : v[7:0]);
        rd_chk(lo + 5'h01, m ? v[11:4] : {4'h0, v[11:8]});
      end
      `CHK(control_c, 8'(m))
    end
    b = 8'($urandom);
    wr_reg(OFS_CH0_LOW, 8'h00);
    wr_reg(OFS_CH0_HIGH, b);
    idle(2);
    `CHK(ch0_value, {b, 4'h0})
    rd_chk(OFS_EMPTY_FLAGS, 8'h00);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    step(0, 0, 2'b11, 5'h00, 8'h00);
    idle(3);
    `CHK(dma_req, 2'b11)
    rd_chk(OFS_EMPTY_FLAGS, 8'h03);
    wait_irq(1'b1);
    rd_chk(OFS_IRQ_MASK, 8'h0D);
    // Clearing status must leave the empty flags alone
    wr_reg(OFS_EMPTY_FLAGS, 8'h01);
    idle(1);
    wait_irq(1'b0);
    rd_chk(OFS_IRQ_MASK, 8'h09);
    rd_chk(OFS_EMPTY_FLAGS, 8'h03);
    wr_reg(OFS_CH1_HIGH, 8'h00);
    idle(3);
    `CHK(dma_req, 2'b01)
    rd_chk(OFS_EMPTY_FLAGS, 8'h01);
    idle(1);
    give_verdict();
  end
endmodule
`default_nettype wire
